/* File: dv/dcc_mem_model.sv */
`timescale 1ns/10ps
module dcc_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic mem_wr_valid,
    output logic mem_wr_ready,
    input wire logic [31:0] mem_wr_addr,
    input wire logic [31:0] mem_wr_data
);
    logic [31:0] log_addr [0:255];
    logic [31:0] log_data [0:255];
    int beat_count = 0;
    logic [1:0] phase_reg;

    // Slow mode takes one beat in four so the buffer backs up
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_wr_ready <= 1'b0;
            phase_reg <= 2'h0;
        end else begin
            if (mem_wr_valid && mem_wr_ready && beat_count < 256) begin
                log_addr[beat_count] <= mem_wr_addr;
                log_data[beat_count] <= mem_wr_data;
                beat_count <= beat_count + 1;
            end
            phase_reg <= phase_reg + 2'h1;
            mem_wr_ready <= !slow || (phase_reg == 2'h3);
        end
    end
endmodule // dcc_mem_model

/* File: dv/tb.sv */
`timescale 1ns/10ps
module tb import dcc_pkg::*; ();
    localparam int SETS = 8;
    localparam logic [24:0] TAG = 25'h000_0040;
    localparam logic [31:0] LINE = 32'h0000_2020;
    logic clk = 0, rst_n = 0, op_valid = 0, execution_mode_field = 1, mem_quiet = 1;
    logic [31:0] op_src1 = 0, op_src2 = 0, op_srcdst = 0, fill_data = 0;
    logic fill_valid = 0, fill_way = 0, slow = 0;
    logic [2:0] fill_set = 0;
    logic [1:0] fill_word = 0;
    logic [24:0] fill_tag = 0;
    logic op_ready, op_done, result_write, privilege_mismatch_fault, invalid_operand_fault;
    logic cache_enabled, fill_ready, mem_wr_valid, mem_wr_ready, pf, iof, rw;
    logic [31:0] op_result, mem_wr_addr, mem_wr_data;
    int mismatches = 0, check_count = 0, base;
    localparam int DLY = 1;
    localparam int LIMIT = 2000;

`define CHK(got, exp) begin \
    check_count++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

    always #50 clk = ~clk;

    dcc_unit #(.SETS(SETS), .WAYS(1), .FIFO_DEPTH(8)) dut (
        .clk(clk),
        .rst_n(rst_n),
        .op_valid(op_valid),
        .op_ready(op_ready),
        .op_src1(op_src1),
        .op_src2(op_src2),
        .op_srcdst(op_srcdst),
        .execution_mode_field(execution_mode_field),
        .mem_quiet(mem_quiet),
        .op_done(op_done),
        .result_write(result_write),
        .op_result(op_result),
        .privilege_mismatch_fault(privilege_mismatch_fault),
        .invalid_operand_fault(invalid_operand_fault),
        .cache_enabled(cache_enabled),
        .fill_valid(fill_valid),
        .fill_ready(fill_ready),
        .fill_set(fill_set),
        .fill_way(fill_way),
        .fill_word(fill_word),
        .fill_tag(fill_tag),
        .fill_data(fill_data),
        .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data)
    );

    dcc_mem_model u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .slow(slow),
        .mem_wr_valid(mem_wr_valid),
        .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Holds the request until the completion pulse, then takes the flags
    task automatic issue(input logic [7:0] code, input logic [31:0] addr,
                         input logic [31:0] sets);
        int n;
        n = 0;
        @(posedge clk);
        #DLY;
        op_src1 = {24'h00_0000, code};
        op_src2 = addr;
        op_srcdst = sets;
        op_valid = 1'b1;
        do begin
            @(posedge clk);
            #DLY;
            n++;
        end while (!op_done && n < LIMIT);
        op_valid = 1'b0;
        pf = privilege_mismatch_fault;
        iof = invalid_operand_fault;
        rw = result_write;
        if (n >= LIMIT) begin
            mismatches++;
            $display("mismatch at %0t: operation never completed", $time);
        end
    endtask

    task automatic fill(input logic [1:0] w);
        @(posedge clk);
        #DLY;
        fill_set = 3'h2;
        fill_word = w;
        fill_tag = TAG;
        fill_data = 32'hD000_0000 + 32'(w);
        fill_valid = 1'b1;
        do begin
            @(posedge clk);
        end while (!fill_ready);
        #DLY;
        fill_valid = 1'b0;
    endtask

    task automatic fill_line();
        for (int w = 0; w < 4; w++) begin
            fill(2'(w));
        end
    endtask

    // Dumps set 2 and checks all seven words against the line layout
    task automatic dump(input logic [31:0] addr, input logic [31:0] vb);
        int b;
        logic [31:0] e;
        b = u_mem.beat_count;
        issue(FN_STORE, addr, 32'h0002_0002);
        `CHK(iof, 1'b0)
        `CHK(u_mem.beat_count - b, 7)
        for (int i = 0; i < 7; i++) begin
            e = (i == 0) ? SET_DATA_WORD : (i == 1) ? 32'(TAG) : (i == 2) ? vb
                : 32'hD000_0000 + 32'(i - 3);
            `CHK(u_mem.log_addr[b + i], addr + 32'(4 * i))
            `CHK(u_mem.log_data[b + i], e)
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #DLY;
        rst_n = 1'b1;
        issue(FN_STATUS, 32'h0000_0000, 32'h0000_0000);
        `CHK(rw, 1'b1)
        `CHK(op_result[3:1], 3'h0)
        `CHK(op_result[27:16], 12'h000)
        `CHK(op_result, {4'h0, 12'h000, 4'($clog2(SETS)), LOG2_LINE_ATOMS,
            LOG2_ATOM_BYTES, 3'h0, EN_RESET})
        mem_quiet = 1'b0;
        fork
            issue(FN_ENABLE, 32'h0000_0000, 32'h0000_0000);
            begin
                repeat (5) @(posedge clk);
                `CHK(cache_enabled, 1'b0)
                #DLY;
                mem_quiet = 1'b1;
            end
        join
        `CHK(cache_enabled, 1'b1)
        issue(FN_STATUS, 32'h0000_0000, 32'h0000_0000);
        `CHK(op_result[0], 1'b1)
        execution_mode_field = 1'b0;
        issue(FN_DISABLE, 32'h0000_0000, 32'h0000_0000);
        `CHK(pf, 1'b1)
        `CHK(cache_enabled, 1'b1)
        execution_mode_field = 1'b1;
        issue(8'h05, 32'h0000_0000, 32'h0000_0000);
        `CHK(iof, 1'b1)
        `CHK(cache_enabled, 1'b1)
        issue(8'hFF, 32'h0000_0000, 32'h0000_0000);
        `CHK(iof, 1'b1)
        issue(FN_DISABLE, 32'h0000_0000, 32'h0000_0000);
        `CHK(cache_enabled, 1'b0)
        `CHK(iof, 1'b0)
        issue(FN_STORE, 32'h0000_4002, 32'h0002_0002);
        `CHK(iof, 1'b1)
        issue(FN_STORE, 32'h0000_4000, 32'h0002_0003);
        `CHK(iof, 1'b1)
        base = u_mem.beat_count;
        issue(FN_STORE, 32'h0000_6000, 32'hFFFF_0007);
        `CHK(iof, 1'b0)
        `CHK(u_mem.beat_count - base, 7)
        `CHK(u_mem.log_addr[base], 32'h0000_6000)
        slow = 1'b1;
        fill_line();
        dump(LINE, 32'h0000_001F);
        slow = 1'b0;
        dump(32'h0000_4000, 32'h0000_0001);
        fill_line();
        issue(FN_COHERE, 32'h0000_0000, 32'h0000_0000);
        dump(32'h0000_4000, 32'h0000_0000);
        fill_line();
        issue(FN_INVAL, 32'h0000_0000, 32'h0000_0000);
        dump(32'h0000_4000, 32'h0000_0000);
        issue(FN_ENABLE, 32'h0000_0000, 32'h0000_0000);
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #DLY;
        rst_n = 1'b1;
        issue(FN_STATUS, 32'h0000_0000, 32'h0000_0000);
        `CHK(op_result[0], EN_RESET)
        end_of_test();
    end

    // Watchdog: the whole run needs a few hundred cycles at most
    initial begin
        #(LIMIT * 1000);
        mismatches++;
        end_of_test();
    end
endmodule // tb

/* File: rtl/dcc_fifo.sv */
`timescale 1ns/10ps
module dcc_fifo #(
    parameter int W = 64,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    dcc_stream_if.snk wr,
    dcc_stream_if.src rd
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } dcc_fifo_type;
    dcc_fifo_type r_reg;
    dcc_fifo_type r_next;
    logic [W-1:0] mem [D];
    logic push;
    logic pop;

    assign wr.ready = r_reg.cnt != (AW+1)'(D);
    assign rd.valid = r_reg.cnt != '0;
    assign rd.data = mem[r_reg.rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_comb begin
        r_next = r_reg;
        if (push) begin
            r_next.wp = r_reg.wp + 1'b1;
        end
        if (pop) begin
            r_next.rp = r_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            r_next.cnt = r_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[r_reg.wp] <= wr.data;
        end
    end
endmodule // dcc_fifo

/* File: rtl/dcc_pkg.sv */
package dcc_pkg;
    localparam int DCC_SETS = 128;
    localparam int DCC_WAYS = 1;
    localparam int DCC_WORDS = 4;
    localparam int DCC_FIFO_DEPTH = 8;
    localparam logic [3:0] LOG2_ATOM_BYTES = 4'h2;
    localparam logic [3:0] LOG2_LINE_ATOMS = 4'h2;
    localparam logic [7:0] FN_DISABLE = 8'h00;
    localparam logic [7:0] FN_ENABLE = 8'h01;
    localparam logic [7:0] FN_INVAL = 8'h02;
    localparam logic [7:0] FN_COHERE = 8'h03;
    localparam logic [7:0] FN_STATUS = 8'h04;
    localparam logic [7:0] FN_STORE = 8'h06;
    localparam int ST_EN_BIT = 0;
    localparam int ST_ATOM_LSB = 4;
    localparam int ST_LINE_LSB = 8;
    localparam int ST_SETS_LSB = 12;
    localparam int ST_WAYS_LSB = 16;
    localparam int VB_TAG_BIT = 0;
    localparam int VB_WORD_LSB = 1;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
    localparam logic [31:0] ALIGN_MASK = 32'h0000_0003;
    localparam logic [31:0] SET_DATA_WORD = 32'h0000_0000;
    localparam logic EN_RESET = 1'b0;
    typedef enum logic [2:0] {ST_IDLE, ST_DUMP, ST_DRAIN, ST_SWEEP} dcc_state_type;
    typedef enum logic [1:0] {PH_SET, PH_TAG, PH_VALID, PH_WORD} dcc_phase_type;
endpackage

/* File: rtl/dcc_stream_if.sv */
`timescale 1ns/10ps
interface dcc_stream_if #(parameter int W = 64);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface

/* File: rtl/dcc_unit.sv */
`timescale 1ns/10ps
module dcc_unit import dcc_pkg::*; #(
    parameter int SETS = DCC_SETS,
    parameter int WAYS = DCC_WAYS,
    parameter int FIFO_DEPTH = DCC_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic op_valid,
    output logic op_ready,
    input wire logic [31:0] op_src1,
    input wire logic [31:0] op_src2,
    input wire logic [31:0] op_srcdst,
    input wire logic execution_mode_field,
    input wire logic mem_quiet,
    output logic op_done,
    output logic result_write,
    output logic [31:0] op_result,
    output logic privilege_mismatch_fault,
    output logic invalid_operand_fault,
    output logic cache_enabled,
    input wire logic fill_valid,
    output logic fill_ready,
    input wire logic [$clog2(SETS)-1:0] fill_set,
    input wire logic [(WAYS>1?$clog2(WAYS):1)-1:0] fill_way,
    input wire logic [1:0] fill_word,
    input wire logic [31-4-$clog2(SETS):0] fill_tag,
    input wire logic [31:0] fill_data,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [31:0] mem_wr_addr,
    output logic [31:0] mem_wr_data
);
    localparam int SW = $clog2(SETS);
    localparam int WW = WAYS > 1 ? $clog2(WAYS) : 1;
    localparam int TW = 32 - 4 - SW;
    localparam int LINES = SETS * WAYS;

    typedef struct packed {
        dcc_state_type state;
        dcc_phase_type phase;
        logic en;
        logic op_ready;
        logic fill_ready;
        logic done;
        logic res_wr;
        logic f_priv;
        logic f_inval;
        logic [31:0] result;
        logic [SW-1:0] set;
        logic [SW-1:0] last;
        logic [SW-1:0] sweep;
        logic [WW-1:0] way;
        logic [1:0] word;
        logic [31:0] addr;
        logic [31:0] lo;
        logic [31:0] hi;
        logic out_valid;
        logic [63:0] out_data;
        logic [LINES-1:0] tag_v;
        logic [LINES*DCC_WORDS-1:0] word_v;
    } dcc_regs_type;

    dcc_regs_type r_reg;
    dcc_regs_type r_next;
    logic [1:0] rst_sync_reg;
    logic rst_ok;
    logic [TW-1:0] tag_mem [LINES];
    logic [31:0] data_mem [LINES][DCC_WORDS];
    logic op_take;
    logic fill_take;
    logic [15:0] end_clamp;
    logic [31:0] dump_word;
    logic [31:0] sweep_addr;
    int idx;
    int fidx;

    dcc_stream_if #(.W(64)) push_if ();
    dcc_stream_if #(.W(64)) pop_if ();

    dcc_fifo #(.W(64), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_ok),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_ok = rst_sync_reg[1];

    // Earlier memory work and fills must be finished before an issue
    assign op_take = op_valid && r_reg.op_ready && mem_quiet && !fill_valid;
    assign fill_take = fill_valid && r_reg.fill_ready;
    assign end_clamp = (op_srcdst[31:16] >= 16'(SETS)) ? 16'(SETS - 1)
                                                       : op_srcdst[31:16];
    assign idx = int'(r_reg.set) * WAYS + int'(r_reg.way);
    assign fidx = int'(fill_set) * WAYS + int'(fill_way);
    assign pop_if.ready = !r_reg.out_valid || mem_wr_ready;

    always_comb begin
        dump_word = SET_DATA_WORD;
        case (r_reg.phase)
            PH_TAG: dump_word = 32'(tag_mem[idx]);
            PH_VALID: begin
                dump_word = '0;
                dump_word[VB_TAG_BIT] = r_reg.tag_v[idx];
                dump_word[VB_WORD_LSB +: DCC_WORDS] = r_reg.word_v[idx*DCC_WORDS +: DCC_WORDS];
            end
            PH_WORD: dump_word = data_mem[idx][r_reg.word];
            default: dump_word = SET_DATA_WORD;
        endcase
    end

    always_comb begin
        r_next = r_reg;
        sweep_addr = '0;
        r_next.done = 1'b0;
        r_next.res_wr = 1'b0;
        r_next.f_priv = 1'b0;
        r_next.f_inval = 1'b0;
        push_if.valid = 1'b0;
        push_if.data = {r_reg.addr, dump_word};
        if (r_reg.out_valid && mem_wr_ready) begin
            r_next.out_valid = 1'b0;
        end
        if (pop_if.valid && pop_if.ready) begin
            r_next.out_valid = 1'b1;
            r_next.out_data = pop_if.data;
        end
        if (fill_take) begin
            if (!r_reg.tag_v[fidx] || tag_mem[fidx] != fill_tag) begin
                r_next.word_v[fidx*DCC_WORDS +: DCC_WORDS] = '0;
            end
            r_next.tag_v[fidx] = 1'b1;
            r_next.word_v[fidx*DCC_WORDS + int'(fill_word)] = 1'b1;
        end
        case (r_reg.state)
            ST_IDLE: begin
                if (op_take) begin
                    r_next.done = 1'b1;
                    if (!execution_mode_field) begin
                        r_next.f_priv = 1'b1;
                    end else begin
                        case (op_src1[7:0])
                            FN_DISABLE: r_next.en = 1'b0;
                            FN_ENABLE: r_next.en = 1'b1;
                            FN_INVAL, FN_COHERE: begin
                                r_next.tag_v = '0;
                                r_next.word_v = '0;
                            end
                            FN_STATUS: begin
                                r_next.res_wr = 1'b1;
                                r_next.result = '0;
                                r_next.result[ST_EN_BIT] = r_reg.en;
                                r_next.result[ST_ATOM_LSB +: 4] = LOG2_ATOM_BYTES;
                                r_next.result[ST_LINE_LSB +: 4] = LOG2_LINE_ATOMS;
                                r_next.result[ST_SETS_LSB +: 4] = 4'(SW);
                                r_next.result[ST_WAYS_LSB +: 12] = 12'(WAYS - 1);
                            end
                            FN_STORE: begin
                                if (op_srcdst[15:0] > end_clamp) begin
                                    r_next.f_inval = 1'b1;
                                end else if ((op_src2 & ALIGN_MASK) != '0) begin
                                    r_next.f_inval = 1'b1;
                                end else begin
                                    r_next.done = 1'b0;
                                    r_next.state = ST_DUMP;
                                    r_next.phase = PH_SET;
                                    r_next.set = op_srcdst[SW-1:0];
                                    r_next.last = end_clamp[SW-1:0];
                                    r_next.way = '0;
                                    r_next.word = '0;
                                    r_next.addr = op_src2;
                                    r_next.lo = op_src2;
                                end
                            end
                            default: begin
                                r_next.f_inval = 1'b1;
                                r_next.tag_v = r_reg.tag_v;
                                r_next.word_v = r_reg.word_v;
                            end
                        endcase
                    end
                end
            end
            ST_DUMP: begin
                push_if.valid = 1'b1;
                if (push_if.ready) begin
                    r_next.addr = r_reg.addr + ADDR_STEP;
                    case (r_reg.phase)
                        PH_SET: r_next.phase = PH_TAG;
                        PH_TAG: r_next.phase = PH_VALID;
                        PH_VALID: begin
                            r_next.phase = PH_WORD;
                            r_next.word = '0;
                        end
                        default: begin
                            r_next.word = r_reg.word + 1'b1;
                            if (r_reg.word == 2'(DCC_WORDS - 1)) begin
                                r_next.phase = PH_TAG;
                                r_next.way = r_reg.way + 1'b1;
                                if (int'(r_reg.way) == WAYS - 1) begin
                                    r_next.way = '0;
                                    r_next.phase = PH_SET;
                                    r_next.set = r_reg.set + 1'b1;
                                    if (r_reg.set == r_reg.last) begin
                                        r_next.state = ST_DRAIN;
                                        r_next.hi = r_reg.addr + ADDR_STEP;
                                    end
                                end
                            end
                        end
                    endcase
                end
            end
            ST_DRAIN: begin
                if (!pop_if.valid && !r_reg.out_valid) begin
                    r_next.state = ST_SWEEP;
                    r_next.sweep = '0;
                end
            end
            ST_SWEEP: begin
                for (int wy = 0; wy < WAYS; wy++) begin
                    for (int wd = 0; wd < DCC_WORDS; wd++) begin
                        sweep_addr = {tag_mem[int'(r_reg.sweep)*WAYS+wy], r_reg.sweep,
                                      2'(wd), 2'b00};
                        if (sweep_addr >= r_reg.lo && sweep_addr < r_reg.hi) begin
                            r_next.word_v[(int'(r_reg.sweep)*WAYS+wy)*DCC_WORDS+wd] = 1'b0;
                        end
                    end
                end
                r_next.sweep = r_reg.sweep + 1'b1;
                if (int'(r_reg.sweep) == SETS - 1) begin
                    r_next.state = ST_IDLE;
                    r_next.done = 1'b1;
                end
            end
            default: r_next.state = ST_IDLE;
        endcase
        // Fills stop once a dump is under way, so it sees the issue-time state
        r_next.op_ready = r_next.state == ST_IDLE;
        r_next.fill_ready = r_next.state == ST_IDLE && !op_take;
    end

    always_ff @(posedge clk or negedge rst_ok) begin
        if (!rst_ok) begin
            r_reg <= '0;
            r_reg.state <= ST_IDLE;
            r_reg.phase <= PH_SET;
            r_reg.en <= EN_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge clk) begin
        if (fill_take) begin
            tag_mem[fidx] <= fill_tag;
            data_mem[fidx][fill_word] <= fill_data;
        end
    end

    assign op_ready = r_reg.op_ready;
    assign fill_ready = r_reg.fill_ready;
    assign op_done = r_reg.done;
    assign result_write = r_reg.res_wr;
    assign op_result = r_reg.result;
    assign privilege_mismatch_fault = r_reg.f_priv;
    assign invalid_operand_fault = r_reg.f_inval;
    assign cache_enabled = r_reg.en;
    assign mem_wr_valid = r_reg.out_valid;
    assign mem_wr_addr = r_reg.out_data[63:32];
    assign mem_wr_data = r_reg.out_data[31:0];

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_ok);

    priv_fault_a: assert property (op_take && !execution_mode_field |=>
        privilege_mismatch_fault && op_done && !result_write && $stable(cache_enabled))
        else $error("privilege fault missing");
    disable_a: assert property (op_take && execution_mode_field && op_src1[7:0] == 8'h00
        |=> !cache_enabled && op_done) else $error("disable failed");
    enable_a: assert property (op_take && execution_mode_field && op_src1[7:0] == 8'h01
        |=> cache_enabled && !invalid_operand_fault) else $error("enable failed");
    inval_a: assert property (op_take && execution_mode_field
        && (op_src1[7:0] == 8'h02 || op_src1[7:0] == 8'h03)
        |=> r_reg.tag_v == '0 && r_reg.word_v == '0) else $error("invalidate failed");
    status_word_a: assert property (op_take && execution_mode_field
        && op_src1[7:0] == 8'h04 |=> result_write && op_result[0] == $past(cache_enabled)
        && op_result[3:1] == 3'h0 && op_result[15:4] == {4'(SW), 4'h2, 4'h2}
        && op_result[27:16] == 12'(WAYS - 1)) else $error("status word wrong");
    range_fault_a: assert property (op_take && execution_mode_field
        && op_src1[7:0] == 8'h06 && op_srcdst[15:0] > end_clamp
        |=> invalid_operand_fault ##1 r_reg.state == ST_IDLE) else $error("range fault missing");
    align_fault_a: assert property (op_take && execution_mode_field
        && op_src1[7:0] == 8'h06 && op_src2[1:0] != 2'b00 |=> invalid_operand_fault)
        else $error("alignment fault missing");
    reserved_code_a: assert property (op_take && execution_mode_field
        && op_src1[7:0] > 8'h04 && op_src1[7:0] != 8'h06
        |=> invalid_operand_fault && $stable(r_reg.tag_v) && $stable(cache_enabled))
        else $error("reserved code accepted");
    addr_step_a: assert property (push_if.valid && push_if.ready
        |=> r_reg.addr == $past(r_reg.addr) + 32'h0000_0004) else $error("address step wrong");
    valid_word_a: assert property (push_if.valid && r_reg.phase == PH_VALID
        |-> push_if.data[31:5] == 27'h0) else $error("valid word reserved bits set");
    drain_done_a: assert property (r_reg.state == ST_SWEEP
        |-> !mem_wr_valid && !pop_if.valid) else $error("done before bus drained");

    store_op_c: cover property (r_reg.state == ST_SWEEP ##1 op_done);
    stall_c: cover property (mem_wr_valid && !mem_wr_ready && !push_if.ready);
    status_c: cover property (result_write);
    priv_c: cover property (privilege_mismatch_fault);
endmodule // dcc_unit
